//--- src/uic_params.svh
// Constants for the USB device IN endpoint and interrupt controller
`ifndef UIC_PARAMS_SVH
`define UIC_PARAMS_SVH
// Register offsets (word addresses, one 32-bit word each)
`define UIC_OFF_CTRL     4'h0
`define UIC_OFF_FLAGS    4'h1
`define UIC_OFF_IEN      4'h2
`define UIC_OFF_ADDR     4'h3
`define UIC_OFF_EPINT    4'h4
`define UIC_OFF_EPIEN    4'h5
`define UIC_OFF_EPCMD    4'h6
`define UIC_OFF_EPSTAT   4'h7
// Control bit positions
`define UIC_CTRL_DETACH  0
`define UIC_CTRL_WAKE    1
`define UIC_CTRL_LS      2
`define UIC_CTRL_CPURST  3
// Device flag positions
`define UIC_FL_SUSP      0
`define UIC_FL_SOF       2
`define UIC_FL_EORST     3
`define UIC_FL_WAKE      4
`define UIC_FL_EORSM     5
`define UIC_FL_UPRSM     6
`define UIC_FL_MASK      8'h7d
// Endpoint flag positions
`define UIC_EP_TXRDY     0
`define UIC_EP_STALL     1
`define UIC_EP_RXOUT     2
`define UIC_EP_RXSTP     3
`define UIC_EP_NAKOUT    4
`define UIC_EP_UNDER     5
`define UIC_EP_NAKIN     6
`define UIC_EP_OVER      7
// Endpoint command bits
`define UIC_CMD_BANKCTL  0
`define UIC_CMD_KILL     1
`define UIC_CMD_WRBYTE   2
// Address register
`define UIC_ADDR_EN      7
// Reset values
`define UIC_CTRL_RST     8'h01
`define UIC_IEN_RST      8'h08
// Bank size in bytes and resume timing
`define UIC_BANK_BYTES   8'h40
`define UIC_RESUME_US    2000
`define UIC_CLK_MHZ      20
`define UIC_RESUME_CYC   ((`UIC_RESUME_US * `UIC_CLK_MHZ))
`define UIC_BUS_ERR      32'hdead_0000
`endif

//--- src/uic_pkg.sv
// Types for the USB device IN endpoint and interrupt controller
package uic_pkg;
   typedef struct packed {
      logic       sof;
      logic       sof_crc_err;
      logic       idle_3ms;
      logic       line_wake;
      logic       bus_reset_end;
      logic       resume_end;
      logic       host_in_token;
      logic       out_pkt;
      logic       out_crc_err;
      logic       out_too_big;
      logic       setup_pkt;
      logic       nak_in;
      logic       nak_out;
      logic       iso;
   } uic_usb_ev_t;
   typedef struct packed {
      logic       pullup_dp;
      logic       pullup_dm;
      logic       resume_drive;
      logic       cpu_reset;
      logic [6:0] dev_addr;
      logic       addr_active;
   } uic_usb_out_t;
   typedef struct packed {
      logic [1:0] busy;
      logic       cur;
      logic [7:0] count;
      logic       last;
   } uic_bank_t;
endpackage

//--- src/uic_bank.sv
// Two-bank IN endpoint bookkeeping
`timescale 1ns/1ps
`include "uic_params.svh"
module uic_bank
   import uic_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             release_bank,
   input  wire logic             kill,
   input  wire logic             wr_byte,
   input  wire logic             host_take,
   output uic_pkg::uic_bank_t    st,
   output logic                  cur_free,
   output logic                  empty
);
   uic_bank_t s, next_s;

   // Current bank free unless both banks are busy, empty when none is busy
   assign cur_free = (s.busy != 2'b10);
   assign empty    = (s.busy == 2'b00);
   assign st       = s;

   // Queue, drain and kill banks
   always_comb
   begin
      next_s = s;
      if (wr_byte && s.count != `UIC_BANK_BYTES)
         next_s.count = s.count + 8'h01;
      if (release_bank && s.busy != 2'b10)
      begin
         next_s.busy  = s.busy + 2'b01;
         next_s.last  = s.cur;
         next_s.cur   = ~s.cur;
         next_s.count = 8'h00;
      end
      else if (kill && s.busy != 2'b00)
      begin
         next_s.busy = s.busy - 2'b01;
         next_s.cur  = s.last;
      end
      if (host_take && s.busy != 2'b00 && !(release_bank || kill))
         next_s.busy = s.busy - 2'b01;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         s <= '0;
      else
         s <= next_s;
   end
endmodule

//--- src/uic_ctrl.sv
// Device control, interrupt flags and IN endpoint logic on Avalon-MM
//
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`include "uic_params.svh"
//
// Function
// - Free bank raises tx ready and bank control
// - Bank control clear queues bank, switches
// - rw allowed high while bank not full
// - Second free bank sets tx ready again
// - Kill bank discards last written bank
// - Iso underflow on empty read, not on full
// - Iso OUT CRC error sets stalled, rx out
// - Oversized OUT sets overflow and rx out
// - Eight endpoint flags gated into endpoint irq
// - SOF sets frame start flag
// - Three ms idle sets suspend flag
// - CPU reset on bus reset end
// - Speed bit picks D+ or D- pull-up
// - Remote wake starts resume, hardware clears
// - Detach disconnects pull-up
// - Upstream resume and resume end flags
// - Line wake flag not on own resume
// - Bus reset end sets its flag
// - Flags set regardless of enables, software clears
// - Enable mirrors flags, reset-end enable set
// - Address enable cleared only by hardware
// - Detach resets to one
// - Wake and suspend flags clear each other
module uic_ctrl
   import uic_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic [3:0]       address,
   input  wire logic             read,
   input  wire logic             write,
   input  wire logic [31:0]      writedata,
   output logic [31:0]           readdata,
   output logic                  waitrequest,
   input  wire logic             usb_enable,
   input  uic_pkg::uic_usb_ev_t  ev,
   output uic_pkg::uic_usb_out_t usb_o,
   output logic                  dev_irq,
   output logic                  ep_irq
);
   import uic_pkg::*;

   typedef struct packed {
      logic [7:0]    ctrl;
      logic [7:0]    flags;
      logic [7:0]    ien;
      logic [7:0]    addr;
      logic [7:0]    epint;
      logic [7:0]    epien;
      logic          bankctl;
      logic          rw_allowed;
      logic          resuming;
      logic [15:0]   rcnt;
      logic          ack;
      logic [31:0]   rdata;
      uic_usb_out_t  uo;
      logic          dirq;
      logic          eirq;
   } uic_state_t;

   uic_state_t r, next_r;
   uic_bank_t  bst;
   logic       cur_free;
   logic       bank_empty;
   logic       acc;
   logic       wr;
   logic       release_bank;
   logic       kill;
   logic       wr_byte;
   logic       host_take;
   logic [7:0] wd;

   // Write zero clears a flag, one leaves it alone
   function automatic logic [7:0] clr0(input logic [7:0] cur, input logic [7:0] w);
      clr0 = cur & w;
   endfunction

   // One wait cycle per access: request taken when ack is low, answered next
   assign acc  = (read || write) && !r.ack;
   // Write lands at the edge where the master sees waitrequest low
   assign wr   = write && r.ack;
   assign wd   = writedata[7:0];
   assign release_bank = wr && address == `UIC_OFF_EPCMD
                         && wd[`UIC_CMD_BANKCTL] && r.bankctl;
   assign kill      = wr && address == `UIC_OFF_EPCMD && wd[`UIC_CMD_KILL];
   assign wr_byte   = wr && address == `UIC_OFF_EPCMD && wd[`UIC_CMD_WRBYTE];
   assign host_take = ev.host_in_token && !bank_empty;

   uic_bank u_bank
   (
      .clk          (clk),
      .reset        (reset),
      .release_bank (release_bank),
      .kill         (kill),
      .wr_byte      (wr_byte),
      .host_take    (host_take),
      .st           (bst),
      .cur_free     (cur_free),
      .empty        (bank_empty)
   );

   assign readdata    = r.rdata;
   assign waitrequest = !r.ack;
   assign usb_o       = r.uo;
   assign dev_irq     = r.dirq;
   assign ep_irq      = r.eirq;

   // Next-state logic: software writes first, hardware sets override
   always_comb
   begin
      next_r     = r;
      next_r.ack = acc;
      if (acc && read)
      begin
         case (address)
            `UIC_OFF_CTRL:   next_r.rdata = {24'h00_0000, r.ctrl};
            `UIC_OFF_FLAGS:  next_r.rdata = {24'h00_0000, r.flags};
            `UIC_OFF_IEN:    next_r.rdata = {24'h00_0000, r.ien};
            `UIC_OFF_ADDR:   next_r.rdata = {24'h00_0000, r.addr};
            `UIC_OFF_EPINT:  next_r.rdata = {24'h00_0000, r.epint};
            `UIC_OFF_EPIEN:  next_r.rdata = {24'h00_0000, r.epien};
            `UIC_OFF_EPCMD:  next_r.rdata = {24'h00_0000, 7'h00, r.bankctl};
            `UIC_OFF_EPSTAT: next_r.rdata = {20'h0_0000, bst.busy,
                                            bst.cur, bst.count, r.rw_allowed};
            default:         next_r.rdata = `UIC_BUS_ERR;
         endcase
      end
      if (wr)
      begin
         case (address)
            `UIC_OFF_CTRL:
            begin
               next_r.ctrl[`UIC_CTRL_DETACH] = wd[`UIC_CTRL_DETACH];
               next_r.ctrl[`UIC_CTRL_LS]     = wd[`UIC_CTRL_LS];
               next_r.ctrl[`UIC_CTRL_CPURST] = wd[`UIC_CTRL_CPURST];
               if (wd[`UIC_CTRL_WAKE] && r.flags[`UIC_FL_SUSP])
                  next_r.ctrl[`UIC_CTRL_WAKE] = 1'b1;
            end
            `UIC_OFF_FLAGS: next_r.flags = clr0(r.flags, wd);
            `UIC_OFF_IEN:   next_r.ien   = wd & `UIC_FL_MASK;
            `UIC_OFF_ADDR:
            begin
               next_r.addr[6:0] = wd[6:0];
               if (wd[`UIC_ADDR_EN])
                  next_r.addr[`UIC_ADDR_EN] = 1'b1;
            end
            `UIC_OFF_EPINT: next_r.epint = clr0(r.epint, wd);
            `UIC_OFF_EPIEN: next_r.epien = wd;
            `UIC_OFF_EPCMD:
               if (release_bank)
                  next_r.bankctl = 1'b0;
            default: ;
         endcase
      end
      // Hardware sets win over software clears
      if (ev.sof)
         next_r.flags[`UIC_FL_SOF] = 1'b1;
      if (ev.idle_3ms)
      begin
         next_r.flags[`UIC_FL_SUSP] = 1'b1;
         next_r.flags[`UIC_FL_WAKE] = 1'b0;
      end
      if (ev.line_wake && !r.resuming)
      begin
         next_r.flags[`UIC_FL_WAKE] = 1'b1;
         next_r.flags[`UIC_FL_SUSP] = 1'b0;
      end
      if (ev.bus_reset_end)
      begin
         next_r.flags[`UIC_FL_EORST] = 1'b1;
         next_r.addr[`UIC_ADDR_EN]   = 1'b0;
      end
      if (ev.resume_end)
         next_r.flags[`UIC_FL_EORSM] = 1'b1;
      // Upstream resume sequencing
      if (r.ctrl[`UIC_CTRL_WAKE] && !r.resuming)
      begin
         next_r.resuming = 1'b1;
         next_r.rcnt     = 16'h0000;
         next_r.flags[`UIC_FL_UPRSM] = 1'b1;
         next_r.flags[`UIC_FL_SUSP]  = 1'b0;
      end
      else if (r.resuming)
      begin
         if (r.rcnt == 16'(`UIC_RESUME_CYC - 1))
         begin
            next_r.resuming = 1'b0;
            next_r.ctrl[`UIC_CTRL_WAKE] = 1'b0;
         end
         else
            next_r.rcnt = r.rcnt + 16'h0001;
      end
      // Endpoint flags
      // On release the flags follow the next bank, which is free if none was busy
      if (release_bank)
         next_r.bankctl = (bst.busy == 2'b00);
      else
         next_r.bankctl = r.bankctl | cur_free;
      if (next_r.bankctl && (!r.bankctl || release_bank))
         next_r.epint[`UIC_EP_TXRDY] = 1'b1;
      next_r.rw_allowed = cur_free && bst.count != `UIC_BANK_BYTES;
      if (ev.iso && ((ev.host_in_token && bank_empty) || ev.out_pkt && 1'b0))
         next_r.epint[`UIC_EP_UNDER] = 1'b1;
      if (ev.out_pkt)
         next_r.epint[`UIC_EP_RXOUT] = 1'b1;
      if (ev.iso && ev.out_pkt && ev.out_crc_err)
         next_r.epint[`UIC_EP_STALL] = 1'b1;
      if (ev.out_pkt && ev.out_too_big)
         next_r.epint[`UIC_EP_OVER] = 1'b1;
      if (ev.setup_pkt)
         next_r.epint[`UIC_EP_RXSTP] = 1'b1;
      if (ev.nak_in)
         next_r.epint[`UIC_EP_NAKIN] = 1'b1;
      if (ev.nak_out)
         next_r.epint[`UIC_EP_NAKOUT] = 1'b1;
      // Oversized iso OUT with CRC error: underflow raised as well
      if (ev.iso && ev.out_pkt && ev.out_too_big && ev.out_crc_err)
         next_r.epint[`UIC_EP_UNDER] = 1'b1;
      if (!usb_enable)
         next_r.ctrl[`UIC_CTRL_CPURST] = 1'b0;
      // Registered outputs
      next_r.dirq = |(r.flags & r.ien);
      next_r.eirq = |(r.epint & r.epien);
      next_r.uo.pullup_dp    = !r.ctrl[`UIC_CTRL_DETACH] && !r.ctrl[`UIC_CTRL_LS];
      next_r.uo.pullup_dm    = !r.ctrl[`UIC_CTRL_DETACH] && r.ctrl[`UIC_CTRL_LS];
      next_r.uo.resume_drive = r.resuming;
      next_r.uo.cpu_reset    = ev.bus_reset_end && r.ctrl[`UIC_CTRL_CPURST];
      next_r.uo.dev_addr     = r.addr[6:0];
      next_r.uo.addr_active  = r.addr[`UIC_ADDR_EN];
   end

   // Control register reset leaves device detached, reset-end enabled
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         r      <= '0;
         r.ctrl <= `UIC_CTRL_RST;
         r.ien  <= `UIC_IEN_RST;
      end
      else
         r <= next_r;
   end

   // Assertions
   irq_dev_a: assert property (@(posedge clk) disable iff (reset)
      (|(r.flags & r.ien)) |=> dev_irq) else $error("dev irq missing");
   irq_ep_a: assert property (@(posedge clk) disable iff (reset)
      (|(r.epint & r.epien)) |=> ep_irq) else $error("ep irq missing");
   sof_set_a: assert property (@(posedge clk) disable iff (reset)
      ev.sof |=> r.flags[`UIC_FL_SOF]) else $error("sof flag missing");
   susp_set_a: assert property (@(posedge clk) disable iff (reset)
      ev.idle_3ms && !(ev.line_wake && !r.resuming) |=> r.flags[`UIC_FL_SUSP]
         && !r.flags[`UIC_FL_WAKE]) else $error("suspend flag wrong");
   eorst_set_a: assert property (@(posedge clk) disable iff (reset)
      ev.bus_reset_end |=> r.flags[`UIC_FL_EORST] && !r.addr[`UIC_ADDR_EN])
      else $error("reset end flag missing");
   pullup_sel_a: assert property (@(posedge clk) disable iff (reset)
      !r.ctrl[`UIC_CTRL_DETACH] |=> usb_o.pullup_dp != usb_o.pullup_dm)
      else $error("pull-up select wrong");
   detach_off_a: assert property (@(posedge clk) disable iff (reset)
      r.ctrl[`UIC_CTRL_DETACH] |=> !usb_o.pullup_dp && !usb_o.pullup_dm)
      else $error("detach not honoured");
   over_set_a: assert property (@(posedge clk) disable iff (reset)
      ev.out_pkt && ev.out_too_big |=> r.epint[`UIC_EP_OVER]
         && r.epint[`UIC_EP_RXOUT]) else $error("overflow flag missing");
   rw_allowed_full_a: assert property (@(posedge clk) disable iff (reset)
      bst.count == `UIC_BANK_BYTES |=> !r.rw_allowed) else $error("rw_allowed on full");
   wake_end_a: assert property (@(posedge clk) disable iff (reset)
      $fell(r.resuming) |-> !r.ctrl[`UIC_CTRL_WAKE]) else $error("wake not cleared");
   cv_resume_c: cover property (@(posedge clk) $rose(r.resuming));
   cv_release_c: cover property (@(posedge clk) release_bank);
   cv_kill_c: cover property (@(posedge clk) kill);
endmodule

//--- bench/uic_host_model.sv
// Host side model: turns bench requests into bus event pulses
`timescale 1ns/1ps
module uic_host_model
   import uic_pkg::*;
(
   input  wire logic            clk,
   output uic_pkg::uic_usb_ev_t ev
);
   // Quiet bus at start
   initial ev = '0;

   // Packets and tokens last one clock; iso stays as a level for the endpoint
   task automatic send(input uic_usb_ev_t e);
      uic_usb_ev_t idle;
      idle     = '0;
      idle.iso = e.iso;
      @(posedge clk);
      ev <= e;
      @(posedge clk);
      ev <= idle;
   endtask
endmodule

//--- bench/test_usb_device_in_ep_and_irq_ctrl.sv
// Self-checking bench for device control, flags and the IN endpoint
`timescale 1ns/1ps
`include "uic_params.svh"
module test_usb_device_in_ep_and_irq_ctrl;
   import uic_pkg::*;
   logic         clk, reset, read, write, usb_enable, waitrequest, dev_irq, ep_irq;
   logic [3:0]   address;
   logic [31:0]  writedata, readdata, d;
   uic_usb_ev_t  ev;
   uic_usb_out_t usb_o;
   int           mismatches, n_checks, n_cpurst, n;

   // ----------------------------------------
   // Design, far side and clock
   // ----------------------------------------
   uic_ctrl dut_u (.clk(clk), .reset(reset), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .usb_enable(usb_enable), .ev(ev),
      .usb_o(usb_o), .dev_irq(dev_irq), .ep_irq(ep_irq));
   uic_host_model host_u (.clk(clk), .ev(ev));

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Count cpu reset pulses, they stand one cycle only
   always @(negedge clk)
      if (usb_o.cpu_reset === 1'b1)
         n_cpurst++;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One Avalon access, held until waitrequest is seen low
   task automatic bus(input logic rw, input logic [3:0] a, input logic [31:0] wd);
      @(posedge clk);
      read      <= !rw;
      write     <= rw;
      address   <= a;
      writedata <= wd;
      n = 0;
      // Look between edges so the registered answer is settled
      do
      begin
         @(negedge clk);
         n++;
      end
      while (waitrequest !== 1'b0 && n < 50);
      d = readdata;
      @(posedge clk);
      read  <= 1'b0;
      write <= 1'b0;
      chk(n < 50, 1);
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      bus(0, a, 32'h0000_0000);
      chk(d, exp);
   endtask

   // Bits: sof crcerr idle wake rstend rsmend in out crc big setup nakin nakout iso
   task automatic hev(input logic [13:0] v);
      host_u.send(uic_usb_ev_t'(v));
      repeat (3) @(posedge clk);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      rd(`UIC_OFF_CTRL, 32'h0000_0001);
      rd(`UIC_OFF_IEN, 32'h0000_0008);
      rd(`UIC_OFF_FLAGS, 32'h0000_0000);
      rd(4'h9, `UIC_BUS_ERR);
      chk({usb_o.pullup_dp, usb_o.pullup_dm}, 2'b00);
   endtask

   task automatic t_pullup();
      wr_wait(8'h00);
      chk({usb_o.pullup_dp, usb_o.pullup_dm}, 2'b10);
      wr_wait(8'h04);
      chk({usb_o.pullup_dp, usb_o.pullup_dm}, 2'b01);
      wr_wait(8'h05);
      chk({usb_o.pullup_dp, usb_o.pullup_dm}, 2'b00);
      wr_wait(8'h02);
      rd(`UIC_OFF_CTRL, 32'h0000_0000);
   endtask

   task automatic wr_wait(input logic [7:0] v);
      bus(1, `UIC_OFF_CTRL, {24'h00_0000, v});
      repeat (3) @(posedge clk);
   endtask

   task automatic t_flags();
      hev(14'h2000);
      hev(14'h0200);
      hev(14'h0100);
      rd(`UIC_OFF_FLAGS, 32'h0000_002c);
      chk(dev_irq, 1);
      chk(n_cpurst, 0);
      bus(1, `UIC_OFF_FLAGS, 32'h0000_00ff);
      rd(`UIC_OFF_FLAGS, 32'h0000_002c);
      bus(1, `UIC_OFF_FLAGS, 32'h0000_00f7);
      rd(`UIC_OFF_FLAGS, 32'h0000_0024);
      chk(dev_irq, 0);
      bus(1, `UIC_OFF_IEN, 32'h0000_0004);
      repeat (3) @(posedge clk);
      chk(dev_irq, 1);
      bus(1, `UIC_OFF_FLAGS, 32'h0000_0000);
      bus(1, `UIC_OFF_IEN, 32'h0000_0000);
   endtask

   task automatic t_susp();
      hev(14'h0800);
      rd(`UIC_OFF_FLAGS, 32'h0000_0001);
      hev(14'h0400);
      rd(`UIC_OFF_FLAGS, 32'h0000_0010);
      hev(14'h0800);
      rd(`UIC_OFF_FLAGS, 32'h0000_0001);
   endtask

   // Resume runs 2 ms, so this scenario dominates the run time
   task automatic t_rwake();
      int k;
      wr_wait(8'h02);
      chk(usb_o.resume_drive, 1);
      bus(0, `UIC_OFF_FLAGS, 32'h0000_0000);
      chk(d[6], 1);
      wr_wait(8'h00);
      rd(`UIC_OFF_CTRL, 32'h0000_0002);
      k = 0;
      while (usb_o.resume_drive === 1'b1 && k < 42000)
      begin
         @(posedge clk);
         k++;
      end
      chk(k > 35000 && k < 42000, 1);
      rd(`UIC_OFF_CTRL, 32'h0000_0000);
      bus(0, `UIC_OFF_FLAGS, 32'h0000_0000);
      chk(d[4], 0);
   endtask

   task automatic t_cpurst();
      wr_wait(8'h08);
      hev(14'h0200);
      chk(n_cpurst, 1);
      rd(`UIC_OFF_CTRL, 32'h0000_0008);
      usb_enable <= 1'b0;
      repeat (3) @(posedge clk);
      usb_enable <= 1'b1;
      rd(`UIC_OFF_CTRL, 32'h0000_0000);
   endtask

   task automatic t_addr();
      bus(1, `UIC_OFF_ADDR, 32'h0000_0085);
      repeat (3) @(posedge clk);
      chk({usb_o.addr_active, usb_o.dev_addr}, 8'h85);
      bus(1, `UIC_OFF_ADDR, 32'h0000_0005);
      rd(`UIC_OFF_ADDR, 32'h0000_0085);
   endtask

   task automatic t_in();
      bus(0, `UIC_OFF_EPINT, 32'h0000_0000);
      chk(d[0], 1);
      rd(`UIC_OFF_EPCMD, 32'h0000_0001);
      bus(1, `UIC_OFF_EPIEN, 32'h0000_0001);
      repeat (3) @(posedge clk);
      chk(ep_irq, 1);
      bus(1, `UIC_OFF_EPINT, 32'h0000_00fe);
      repeat (3) @(posedge clk);
      chk(ep_irq, 0);
      rd(`UIC_OFF_EPSTAT, 32'h0000_0001);
      repeat (64) bus(1, `UIC_OFF_EPCMD, 32'h0000_0004);
      rd(`UIC_OFF_EPSTAT, 32'h0000_0080);
      bus(1, `UIC_OFF_EPCMD, 32'h0000_0001);
      rd(`UIC_OFF_EPSTAT, 32'h0000_0601);
      bus(0, `UIC_OFF_EPINT, 32'h0000_0000);
      chk(d[0], 1);
      bus(1, `UIC_OFF_EPCMD, 32'h0000_0002);
      bus(0, `UIC_OFF_EPSTAT, 32'h0000_0000);
      chk(d[11:10], 2'b00);
   endtask

   task automatic t_ep_err();
      hev(14'h0081);
      bus(0, `UIC_OFF_EPINT, 32'h0000_0000);
      chk(d & 32'h0000_00fe, 32'h0000_0020);
      hev(14'h0061);
      bus(0, `UIC_OFF_EPINT, 32'h0000_0000);
      chk(d & 32'h0000_00fe, 32'h0000_0026);
      hev(14'h0050);
      bus(0, `UIC_OFF_EPINT, 32'h0000_0000);
      chk(d & 32'h0000_00fe, 32'h0000_00a6);
      hev(14'h000e);
      bus(0, `UIC_OFF_EPINT, 32'h0000_0000);
      chk(d & 32'h0000_00fe, 32'h0000_00fe);
      for (int i = 1; i < 8; i++)
      begin
         bus(1, `UIC_OFF_EPIEN, 32'h0000_0001 << i);
         repeat (3) @(posedge clk);
         chk(ep_irq, 1);
      end
      bus(1, `UIC_OFF_EPINT, 32'h0000_0001);
      bus(1, `UIC_OFF_EPIEN, 32'h0000_00fe);
      repeat (3) @(posedge clk);
      chk(ep_irq, 0);
   endtask

   task automatic print_verdict();
      $display("mismatches %0d checks %0d", mismatches, n_checks);
      if (mismatches == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial
   begin
      {reset, read, write, usb_enable} = 4'b1001;
      {address, writedata, mismatches, n_checks, n_cpurst} = '0;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_pullup();
      t_flags();
      t_susp();
      t_rwake();
      t_cpurst();
      t_addr();
      t_in();
      t_ep_err();
      print_verdict();
   end

   initial
   begin
      repeat (70000) @(posedge clk);
      mismatches++;
      print_verdict();
   end
endmodule
